//--- rtl/error_signal_monitor.sv
// Error signal monitor with failure counter and state requests
`timescale 1ns/1ps
`include "esm_cfg.svh"
module error_signal_monitor
    import sigmon_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        mcu_err_in,
    input  wire logic        monitor_enable,
    input  wire logic        monitor_mode_select,
    input  wire thresholds_t thr,
    input  wire limits_t     lim,
    input  wire dev_state_t  dev_state,
    input  wire logic        logic_self_test_done,
    output logic [3:0]       monitor_fail_count,
    output logic             monitor_fail_flag,
    output logic             monitor_reset_fail_flag,
    output logic             go_safe_req,
    output logic             go_reset_req,
    output logic             enable_drive_output,
    output logic             enable_drive_request_ok,
    output logic             error_pulse,
    output logic             good_pulse
);
    mon_state_t            mon_q;
    logic [16:0]           tmr_q;
    logic                  lvl_q;
    logic                  in_q;
    logic                  en_q;
    logic                  mode_q;
    dev_state_t            dev_q;
    logic                  first_done_q;
    logic                  mode_tog;
    logic                  en_rise;
    logic                  en_fall;
    logic                  restart;
    logic                  cnt_init;
    logic                  err_ev;
    logic                  good_ev;
    logic                  edge_ev;
    logic [16:0]           lmax;
    logic [16:0]           hmax;
    logic [16:0]           lmin;
    logic [16:0]           hmin;

    function automatic logic [3:0] sat_step(input logic [3:0] c, input logic up, input logic dn);
        if (up && c != `SIG_CNT_MAX)
            sat_step = c + `SIG_CNT_ONE;
        else if (dn && c != `SIG_CNT_MIN)
            sat_step = c - `SIG_CNT_ONE;
        else
            sat_step = c;
    endfunction : sat_step

    assign lmax     = {1'b0, thr.low_max_threshold};
    assign hmax     = {1'b0, thr.high_max_threshold};
    assign lmin     = {1'b0, thr.low_min_threshold};
    assign hmin     = {1'b0, thr.high_min_threshold};
    assign mode_tog = en_q && (monitor_mode_select != mode_q);
    assign en_rise  = monitor_enable && !en_q;
    assign en_fall  = !monitor_enable && en_q;
    // Restart covers the initialising events and enable rise, but not the counter-only SAFE to DIAG step
    assign restart  = (dev_state == DEV_RESET && dev_q != DEV_RESET) || logic_self_test_done
                      || mode_tog || en_fall || en_rise;
    assign cnt_init = restart || (dev_q == DEV_SAFE && dev_state == DEV_DIAG);
    assign edge_ev  = mcu_err_in != in_q;

    // Monitor sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            mon_q        <= MON_IDLE;
            tmr_q        <= `SIG_TIME_ZERO;
            lvl_q        <= 1'b0;
            first_done_q <= 1'b0;
            err_ev       <= 1'b0;
            good_ev      <= 1'b0;
        end else if (ce) begin
            err_ev  <= 1'b0;
            good_ev <= 1'b0;
            if (restart || !monitor_enable) begin
                mon_q        <= monitor_enable ? MON_WAIT : MON_IDLE;
                tmr_q        <= `SIG_TIME_ZERO;
                first_done_q <= 1'b0;
                lvl_q        <= mcu_err_in;
            end else begin
                case (mon_q)
                    MON_IDLE: begin
                        mon_q <= MON_WAIT;
                        tmr_q <= `SIG_TIME_ZERO;
                    end
                    MON_WAIT: begin
                        tmr_q <= tmr_q + `SIG_TIME_ONE;
                        if (!monitor_mode_select) begin
                            if (in_q && !mcu_err_in) begin
                                mon_q <= MON_PHASE;
                                lvl_q <= 1'b0;
                                tmr_q <= `SIG_TIME_ZERO;
                            end else if (!mcu_err_in && tmr_q + `SIG_TIME_ONE >= lmax + hmax) begin
                                err_ev <= 1'b1;
                                tmr_q  <= `SIG_TIME_ZERO;
                            end else if (mcu_err_in) begin
                                tmr_q <= `SIG_TIME_ZERO;
                            end
                        end else begin
                            if (edge_ev) begin
                                mon_q <= MON_PHASE;
                                lvl_q <= mcu_err_in;
                                tmr_q <= `SIG_TIME_ZERO;
                            end else if (tmr_q + `SIG_TIME_ONE >= lmax + hmax) begin
                                err_ev <= 1'b1;
                                tmr_q  <= `SIG_TIME_ZERO;
                            end
                        end
                    end
                    MON_PHASE: begin
                        tmr_q <= tmr_q + `SIG_TIME_ONE;
                        if (!monitor_mode_select) begin
                            // Low-pulse mode: only the low width is judged
                            if (mcu_err_in) begin
                                good_ev <= 1'b1;
                                mon_q   <= MON_WAIT;
                                tmr_q   <= `SIG_TIME_ZERO;
                            end else if (tmr_q + `SIG_TIME_ONE > lmax) begin
                                err_ev <= 1'b1;
                                tmr_q  <= `SIG_TIME_ZERO;
                                mon_q  <= MON_WAIT;
                            end
                        end else if (edge_ev) begin
                            tmr_q <= `SIG_TIME_ZERO;
                            lvl_q <= mcu_err_in;
                            // Timer plus one is the phase length, same measure as the maximum check
                            if (tmr_q + `SIG_TIME_ONE < (lvl_q ? hmin : lmin)) begin
                                err_ev       <= 1'b1;
                                first_done_q <= 1'b0;
                            end else if (first_done_q) begin
                                good_ev      <= 1'b1;
                                first_done_q <= 1'b0;
                            end else begin
                                first_done_q <= 1'b1;
                            end
                        end else if (tmr_q + `SIG_TIME_ONE > (lvl_q ? hmax : lmax)) begin
                            err_ev       <= 1'b1;
                            first_done_q <= 1'b0;
                            mon_q        <= MON_WAIT;
                            tmr_q        <= `SIG_TIME_ZERO;
                        end
                    end
                    default: mon_q <= MON_IDLE;
                endcase
            end
        end
    end

    // Edge and toggle history
    always_ff @(posedge clk) begin
        if (rst) begin
            in_q   <= 1'b1;
            en_q   <= 1'b0;
            mode_q <= 1'b0;
            dev_q  <= DEV_RESET;
        end else if (ce) begin
            in_q   <= mcu_err_in;
            en_q   <= monitor_enable;
            mode_q <= monitor_mode_select;
            dev_q  <= dev_state;
        end
    end

    // Failure counter
    always_ff @(posedge clk) begin
        if (rst) begin
            monitor_fail_count <= `SIG_CNT_RST;
        end else if (ce) begin
            if (cnt_init)
                monitor_fail_count <= `SIG_CNT_RST;
            else
                monitor_fail_count <= sat_step(monitor_fail_count, err_ev, good_ev);
        end
    end

    // Threshold comparison and state requests
    always_ff @(posedge clk) begin
        if (rst) begin
            monitor_fail_flag       <= 1'b0;
            monitor_reset_fail_flag <= 1'b0;
            go_safe_req             <= 1'b0;
            go_reset_req            <= 1'b0;
            enable_drive_output     <= 1'b0;
            enable_drive_request_ok <= 1'b0;
            error_pulse             <= 1'b0;
            good_pulse              <= 1'b0;
        end else if (ce) begin
            error_pulse  <= err_ev;
            good_pulse   <= good_ev;
            go_safe_req  <= 1'b0;
            go_reset_req <= 1'b0;
            enable_drive_request_ok <= monitor_fail_count <= lim.enable_drive_fail_limit;
            enable_drive_output     <= (dev_state == DEV_ACTIVE || dev_state == DEV_DIAG)
                                       && monitor_fail_count <= lim.enable_drive_fail_limit;
            if (restart) begin
                monitor_fail_flag <= 1'b0;
            end else if (dev_state == DEV_ACTIVE && !lim.fail_reset_select
                         && monitor_fail_count > lim.enable_drive_fail_limit) begin
                go_safe_req             <= 1'b1;
                enable_drive_output     <= 1'b0;
                monitor_fail_flag       <= 1'b1;
                monitor_reset_fail_flag <= 1'b1;
            end else if ((dev_state == DEV_ACTIVE || dev_state == DEV_DIAG)
                         && monitor_fail_count > lim.reset_fail_limit) begin
                monitor_fail_flag       <= 1'b1;
                monitor_reset_fail_flag <= 1'b1;
                if (!lim.fail_reset_select) begin
                    go_safe_req         <= 1'b1;
                    enable_drive_output <= 1'b0;
                end else if (dev_state == DEV_DIAG
                             || lim.reset_fail_limit <= lim.enable_drive_fail_limit) begin
                    go_reset_req <= 1'b1;
                end
            end
        end
    end

    fail_count_sat_a: assert property (@(posedge clk) disable iff (rst)
        ce && !cnt_init && err_ev && monitor_fail_count == `SIG_CNT_MAX |=> monitor_fail_count == `SIG_CNT_MAX)
        else $error("fail count wrapped");
    count_up_a: assert property (@(posedge clk) disable iff (rst)
        ce && !cnt_init && err_ev && !good_ev && monitor_fail_count != `SIG_CNT_MAX
        |=> monitor_fail_count == $past(monitor_fail_count) + `SIG_CNT_ONE)
        else $error("fail count did not increment");
    count_init_a: assert property (@(posedge clk) disable iff (rst)
        ce && cnt_init |=> monitor_fail_count == `SIG_CNT_RST)
        else $error("fail count not initialised");
    disabled_idle_a: assert property (@(posedge clk) disable iff (rst)
        ce && !monitor_enable |=> mon_q == MON_IDLE ##1 !err_ev)
        else $error("monitor ran while disabled");
    safe_request_a: assert property (@(posedge clk) disable iff (rst)
        ce && !restart && dev_state == DEV_ACTIVE && !lim.fail_reset_select
        && monitor_fail_count > lim.enable_drive_fail_limit |=> go_safe_req && !enable_drive_output)
        else $error("missing safe request");
    reset_request_a: assert property (@(posedge clk) disable iff (rst)
        go_reset_req |-> monitor_fail_flag && monitor_reset_fail_flag)
        else $error("reset without flags");
    reset_limit_a: assert property (@(posedge clk) disable iff (rst)
        go_reset_req && $past(dev_state) == DEV_ACTIVE
        |-> $past(lim.reset_fail_limit) <= $past(lim.enable_drive_fail_limit))
        else $error("reset with limit above drive limit");
    restart_clear_a: assert property (@(posedge clk) disable iff (rst)
        ce && restart |=> !monitor_fail_flag)
        else $error("flag not cleared on restart");
    no_edge_err_a: assert property (@(posedge clk) disable iff (rst)
        err_ev |-> ##1 error_pulse || !ce)
        else $error("error pulse lost");
    cov_error: cover property (@(posedge clk) err_ev);
    cov_good: cover property (@(posedge clk) good_ev);
    cov_safe: cover property (@(posedge clk) go_safe_req);
    cov_reset: cover property (@(posedge clk) go_reset_req);
endmodule : error_signal_monitor

//--- rtl/esm_cfg.svh
// Constants and functional notes for the error signal monitor
// Functional notes
// - Two modes: low-pulse width check, or PWM low and high width check.
// - Monitor idle after reset; runs only once monitor_enable is 1.
// - monitor_mode_select picks the mode.
// - Low-pulse mode uses low_max_threshold; high input waits for falling edge.
// - Low at enable and no rise within low max plus high max: error, restart.
// - PWM mode uses four thresholds for low and high minimum and maximum.
// - PWM starts at first edge; none within low max plus high max is error.
// - PWM phase too short or too long is error, counts up, restarts cycle.
// - Fail count decrements on correct signal, increments on error.
// - New monitoring event starts right after any error or correct signal.
// - ACTIVE, count above drive limit, reset select 0: SAFE, drive low, flags.
// - DIAGNOSTIC or ACTIVE, count above reset limit, select 1: RESET, flags.
// - Above reset limit, select 0: SAFE and flags; none if already SAFE.
// - Power-on, RESET entry, self-test end, mode toggle, disable: restart, clear.
// - SAFE to DIAGNOSTIC, RESET, self-test end, enable rise, mode toggle: count default.
// - ACTIVE to RESET by count only when reset limit not above drive limit.
`ifndef SIGMON_CFG_SVH
`define SIGMON_CFG_SVH
`define SIG_CNT_W      4
`define SIG_TIME_W     16
`define SIG_CNT_RST    4'h0
`define SIG_CNT_MAX    4'hf
`define SIG_CNT_MIN    4'h0
`define SIG_CNT_ONE    4'h1
`define SIG_TIME_ZERO  17'h00000
`define SIG_TIME_ONE   17'h00001
`endif

//--- rtl/esm_pkg.sv
// Types for the error signal monitor
package sigmon_pkg;
    typedef enum logic [3:0] {
        DEV_RESET = 4'h1,
        DEV_DIAG  = 4'h2,
        DEV_ACTIVE= 4'h4,
        DEV_SAFE  = 4'h8
    } dev_state_t;
    typedef enum logic [2:0] {
        MON_IDLE  = 3'h1,
        MON_WAIT  = 3'h2,
        MON_PHASE = 3'h4
    } mon_state_t;
    typedef struct packed {
        logic [15:0] low_min_threshold;
        logic [15:0] low_max_threshold;
        logic [15:0] high_min_threshold;
        logic [15:0] high_max_threshold;
    } thresholds_t;
    typedef struct packed {
        logic [3:0] enable_drive_fail_limit;
        logic [3:0] reset_fail_limit;
        logic       fail_reset_select;
    } limits_t;
endpackage : sigmon_pkg

//--- sim/mcu_drv.sv
// Behavioural controller that drives the error signal line
`timescale 1ns/1ps
module mcu_drv (
    input  wire logic clk,
    output logic      err_line
);
    initial err_line = 1'b1;

    // Holds one level for n cycles; called just after a falling edge so changes stay off the sampling edge
    task automatic phase(input logic lvl, input int n);
        err_line = lvl;
        repeat (n) @(negedge clk);
    endtask : phase
endmodule : mcu_drv

//--- sim/mcu_error_signal_monitor_tb.sv
// Self-checking bench for the error signal monitor
`timescale 1ns/1ps
module mcu_error_signal_monitor_tb;
    import sigmon_pkg::*;
    logic        clk       = 1'b0;
    logic        rst       = 1'b1;
    logic        en        = 1'b0;
    logic        mode      = 1'b0;
    logic        logic_self_test     = 1'b0;
    logic        ce        = 1'b1;
    logic        err_line;
    thresholds_t thr       = {16'h0004, 16'h000a, 16'h0004, 16'h000a};
    limits_t     lim       = {4'h3, 4'hf, 1'b0};
    dev_state_t  dev_state = DEV_DIAG;
    logic [3:0]  cnt;
    logic        fail_f, rst_f, safe_r, reset_r, edo, edo_ok, err_p, good_p;
    logic [4:0]  notes[$];
    logic [4:0]  n;
    logic [3:0]  model_cnt = 4'h0;
    int          err_count = 0;
    int          total_checks = 0;
    int          i;
    // Rows: state, reset limit, select, expected safe request, expected reset request; drive limit stays 3
    logic [10:0] rows [6] = '{{4'h4, 4'h8, 1'b0, 2'b10}, {4'h4, 4'h2, 1'b1, 2'b01}, {4'h4, 4'h5, 1'b1, 2'b00},
                              {4'h2, 4'h8, 1'b0, 2'b10}, {4'h2, 4'h8, 1'b1, 2'b01}, {4'h2, 4'hf, 1'b0, 2'b00}};

    always #12.5 clk = ~clk;

    mcu_drv mcu_drv_i (.clk(clk), .err_line(err_line));

    error_signal_monitor error_signal_monitor_i (
        .clk(clk), .rst(rst), .ce(ce), .mcu_err_in(err_line), .monitor_enable(en),
        .monitor_mode_select(mode), .thr(thr), .lim(lim), .dev_state(dev_state),
        .logic_self_test_done(logic_self_test), .monitor_fail_count(cnt), .monitor_fail_flag(fail_f),
        .monitor_reset_fail_flag(rst_f), .go_safe_req(safe_r), .go_reset_req(reset_r),
        .enable_drive_output(edo), .enable_drive_request_ok(edo_ok), .error_pulse(err_p), .good_pulse(good_p));

    task automatic print_verdict();
        if (err_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [4:0] got, input logic [4:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Expected count saturates so a long burst of errors cannot wrap back to a clean value
    task automatic note(input logic good);
        if (good)
            model_cnt = (model_cnt == 4'h0) ? 4'h0 : model_cnt - 4'h1;
        else
            model_cnt = (model_cnt == 4'hf) ? 4'hf : model_cnt + 4'h1;
        notes.push_back({good, model_cnt});
    endtask : note

    task automatic drain();
        int k;
        for (k = 0; k < 1000 && notes.size() != 0; k++) @(negedge clk);
        if (notes.size() != 0) begin
            err_count++;
            print_verdict();
        end
    endtask : drain

    // A pulse with no note pending is compared against its own inverse, so it always counts as a mismatch
    always @(negedge clk) begin
        if (err_p === 1'b1 || good_p === 1'b1) begin
            if (notes.size() == 0)
                n = {~good_p, cnt};
            else
                n = notes.pop_front();
            chk({good_p, cnt}, n);
        end
    end

    initial begin
        void'($urandom(25488));
        repeat (10) @(negedge clk);
        rst = 1'b0;
        chk({err_p, good_p, safe_r, reset_r, edo}, 5'h00);
        mcu_drv_i.phase(1'b0, 5);
        mcu_drv_i.phase(1'b1, 5);
        en = 1'b1;
        mcu_drv_i.phase(1'b1, 3);
        note(1'b1);
        mcu_drv_i.phase(1'b0, 5);
        mcu_drv_i.phase(1'b1, 5);
        note(1'b0);
        mcu_drv_i.phase(1'b0, 15);
        mcu_drv_i.phase(1'b1, 5);
        note(1'b1);
        mcu_drv_i.phase(1'b0, 6);
        mcu_drv_i.phase(1'b1, 5);
        drain();
        en = 1'b0;
        mcu_drv_i.phase(1'b0, 3);
        en = 1'b1;
        model_cnt = 4'h0;
        for (i = 0; i < 17; i++) note(1'b0);
        drain();
        mcu_drv_i.phase(1'b1, 3);
        for (i = 0; i < 6; i++) begin
            dev_state = dev_state_t'(rows[i][10:7]);
            lim = {4'h3, rows[i][6:2]};
            repeat (3) @(negedge clk);
            chk(5'({safe_r, reset_r, edo, edo_ok}), 5'({rows[i][1:0], 2'b00}));
        end
        chk(5'({fail_f, rst_f}), 5'h03);
        dev_state = DEV_RESET;
        model_cnt = 4'h0;
        repeat (3) @(negedge clk);
        chk({cnt, fail_f}, 5'h00);
        dev_state = DEV_ACTIVE;
        lim = {4'h3, 4'hf, 1'b0};
        repeat (3) @(negedge clk);
        chk(5'({edo, edo_ok}), 5'h03);
        note(1'b0);
        mcu_drv_i.phase(1'b0, 15);
        mcu_drv_i.phase(1'b1, 5);
        drain();
        mode = 1'b1;
        model_cnt = 4'h0;
        repeat (3) @(negedge clk);
        chk(5'(cnt), 5'h00);
        note(1'b0);
        mcu_drv_i.phase(1'b1, 22);
        for (i = 0; i < 3; i++) begin
            note(1'b1);
            mcu_drv_i.phase(1'b0, 5 + $urandom % 5);
            mcu_drv_i.phase(1'b1, 5 + $urandom % 5);
        end
        note(1'b0);
        mcu_drv_i.phase(1'b0, 6);
        mcu_drv_i.phase(1'b1, 2);
        note(1'b0);
        mcu_drv_i.phase(1'b0, 6);
        mcu_drv_i.phase(1'b1, 15);
        note(1'b0);
        mcu_drv_i.phase(1'b0, 15);
        note(1'b1);
        mcu_drv_i.phase(1'b1, 6);
        mcu_drv_i.phase(1'b0, 6);
        note(1'b0);
        mcu_drv_i.phase(1'b1, 6);
        mcu_drv_i.phase(1'b0, 2);
        mcu_drv_i.phase(1'b1, 2);
        drain();
        // Clock enable low must freeze the count even across a self-test end
        ce = 1'b0;
        logic_self_test = 1'b1;
        repeat (3) @(negedge clk);
        chk({cnt, fail_f}, 5'h06);
        ce = 1'b1;
        logic_self_test = 1'b1;
        @(negedge clk);
        logic_self_test = 1'b0;
        model_cnt = 4'h0;
        repeat (2) @(negedge clk);
        chk(5'(cnt), 5'h00);
        en = 1'b0;
        repeat (3) @(negedge clk);
        chk({cnt, fail_f}, 5'h00);
        print_verdict();
    end
endmodule : mcu_error_signal_monitor_tb
